// file: shared/pcr_pkg.sv
// Constants, types and decode helpers for the parameter channel responder
package pcr_pkg;

	// Response codes
	typedef enum logic [3:0] {
		PCR_RSP_NONE = 4'b0000,
		PCR_RSP_WORD = 4'b0001,
		PCR_RSP_DWORD = 4'b0010,
		PCR_RSP_DESC = 4'b0011,
		PCR_RSP_ARR_WORD = 4'b0100,
		PCR_RSP_ARR_DWORD = 4'b0101,
		PCR_RSP_ARR_COUNT = 4'b0110,
		PCR_RSP_ERROR = 4'b0111
	} pcr_rsp_t;

	// Error identifiers placed in the value field
	localparam logic [15:0] PCR_ERR_BAD_NUMBER = 16'h0000;
	localparam logic [15:0] PCR_ERR_READ_ONLY = 16'h0001;
	localparam logic [15:0] PCR_ERR_LIMITS = 16'h0002;
	localparam logic [15:0] PCR_ERR_SUB_RANGE = 16'h0003;
	localparam logic [15:0] PCR_ERR_NOT_ARRAY = 16'h0004;
	localparam logic [15:0] PCR_ERR_SIZE = 16'h0005;
	localparam logic [15:0] PCR_ERR_CHAN_SMALL = 16'h0066;
	localparam logic [15:0] PCR_ERR_BAD_VALUE = 16'h0068;
	localparam logic [15:0] PCR_ERR_UNSUPPORTED = 16'h006a;

	// Error selector values written by software
	localparam logic [3:0] PCR_SEL_BAD_NUMBER = 4'h0;
	localparam logic [3:0] PCR_SEL_READ_ONLY = 4'h1;
	localparam logic [3:0] PCR_SEL_LIMITS = 4'h2;
	localparam logic [3:0] PCR_SEL_SUB_RANGE = 4'h3;
	localparam logic [3:0] PCR_SEL_NOT_ARRAY = 4'h4;
	localparam logic [3:0] PCR_SEL_SIZE = 4'h5;
	localparam logic [3:0] PCR_SEL_CHAN_SMALL = 4'h6;
	localparam logic [3:0] PCR_SEL_BAD_VALUE = 4'h7;
	localparam logic [3:0] PCR_SEL_UNSUPPORTED = 4'h8;

	// Identifier word fields
	localparam int PCR_CODE_LSB = 12;
	localparam int PCR_CODE_MSB = 15;
	localparam int PCR_PNU_LSB = 0;
	localparam int PCR_PNU_MSB = 10;

	// Index word fields
	localparam int PCR_SUB_LSB = 0;
	localparam int PCR_SUB_MSB = 7;
	localparam int PCR_PAGE_LSB = 10;
	localparam int PCR_PAGE_MSB = 15;
	localparam int PCR_PAGE_BITS = 6;
	localparam int PCR_FULL_W = 17;

	// Page offset contributed by each index bit 10..15
	localparam logic [16:0] PCR_PAGE_OFS [PCR_PAGE_BITS] = '{
		17'd32000,
		17'd64000,
		17'd4000,
		17'd8000,
		17'd16000,
		17'd2000
	};

	// Channel width in words
	localparam logic [2:0] PCR_WIDTH_WORD = 3'd3;
	localparam logic [2:0] PCR_WIDTH_DWORD = 3'd4;
	localparam logic [2:0] PCR_WIDTH_RESET = 3'd4;

	// Register byte offsets
	localparam logic [7:0] PCR_REG_REQ_ID = 8'h00;
	localparam logic [7:0] PCR_REG_REQ_INDEX = 8'h04;
	localparam logic [7:0] PCR_REG_REQ_VALUE = 8'h08;
	localparam logic [7:0] PCR_REG_DECODE = 8'h0c;
	localparam logic [7:0] PCR_REG_FULL_ID = 8'h10;
	localparam logic [7:0] PCR_REG_RESULT = 8'h14;
	localparam logic [7:0] PCR_REG_RES_VALUE = 8'h18;
	localparam logic [7:0] PCR_REG_RSP_ID = 8'h1c;
	localparam logic [7:0] PCR_REG_RSP_VALUE = 8'h20;
	localparam logic [7:0] PCR_REG_CHAN_WIDTH = 8'h24;
	localparam logic [7:0] PCR_REG_IRQ_STATUS = 8'h28;
	localparam logic [7:0] PCR_REG_IRQ_MASK = 8'h2c;

	// Result control fields
	localparam int PCR_RES_KIND_LSB = 0;
	localparam int PCR_RES_KIND_MSB = 3;
	localparam int PCR_RES_ERR_LSB = 8;
	localparam int PCR_RES_ERR_MSB = 11;

	// Interrupt status bits
	localparam int PCR_IRQ_ORDER = 0;
	localparam int PCR_IRQ_SENT = 1;
	localparam int PCR_IRQ_ERROR = 2;
	localparam int PCR_IRQ_RESERVED = 3;
	localparam int PCR_IRQ_W = 4;

	// Page index to full identifier offset
	function automatic logic [16:0] pcr_page_offset(input logic [15:0] index);
		logic [16:0] sum;
		sum = 17'h00000;
		for (int i = 0; i < PCR_PAGE_BITS; i++) begin
			if (index[PCR_PAGE_LSB + i]) begin
				sum = 17'(sum + PCR_PAGE_OFS[i]);
			end
		end
		return sum;
	endfunction : pcr_page_offset

	// Error selector to error identifier
	function automatic logic [15:0] pcr_err_id(input logic [3:0] sel);
		logic [15:0] id;
		case (sel)
			PCR_SEL_BAD_NUMBER: id = PCR_ERR_BAD_NUMBER;
			PCR_SEL_READ_ONLY: id = PCR_ERR_READ_ONLY;
			PCR_SEL_LIMITS: id = PCR_ERR_LIMITS;
			PCR_SEL_SUB_RANGE: id = PCR_ERR_SUB_RANGE;
			PCR_SEL_NOT_ARRAY: id = PCR_ERR_NOT_ARRAY;
			PCR_SEL_SIZE: id = PCR_ERR_SIZE;
			PCR_SEL_CHAN_SMALL: id = PCR_ERR_CHAN_SMALL;
			PCR_SEL_BAD_VALUE: id = PCR_ERR_BAD_VALUE;
			default: id = PCR_ERR_UNSUPPORTED;
		endcase
		return id;
	endfunction : pcr_err_id

endpackage : pcr_pkg

// file: hdl/pcr_responder.sv
// Parameter channel responder with APB register access
`timescale 1ns/1ps
module pcr_responder
	import pcr_pkg::*;
(
	input wire logic pclk, // Bus clock, 100 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic req_strobe, // Order arrives, one cycle
	input wire logic [15:0] req_id_word, // Master identifier word
	input wire logic [15:0] req_index_word, // Master index word
	input wire logic [31:0] req_value_field, // Master value field
	output logic rsp_strobe, // Response ready, one cycle
	output logic [15:0] parameter_id_word, // Response identifier word
	output logic [15:0] rsp_index_word, // Response index word
	output logic [31:0] parameter_value_field, // Response value field
	output logic irq // Level interrupt
);

	// Captured order
	logic [15:0] order_id;
	logic [15:0] order_index;
	logic [31:0] order_value;

	// Software controls and interrupt status
	logic [31:0] res_value;
	logic [2:0] chan_width;
	logic [PCR_IRQ_W-1:0] irq_mask;
	logic [PCR_IRQ_W-1:0] irq_status;

	// Bus decode
	wire bus_access = psel & penable;
	wire bus_wr = bus_access & pwrite;
	wire bus_rd = bus_access & ~pwrite;
	wire hit_req_id = (paddr == PCR_REG_REQ_ID);
	wire hit_req_index = (paddr == PCR_REG_REQ_INDEX);
	wire hit_req_value = (paddr == PCR_REG_REQ_VALUE);
	wire hit_decode = (paddr == PCR_REG_DECODE);
	wire hit_full_id = (paddr == PCR_REG_FULL_ID);
	wire hit_result = (paddr == PCR_REG_RESULT);
	wire hit_res_value = (paddr == PCR_REG_RES_VALUE);
	wire hit_rsp_id = (paddr == PCR_REG_RSP_ID);
	wire hit_rsp_value = (paddr == PCR_REG_RSP_VALUE);
	wire hit_chan_width = (paddr == PCR_REG_CHAN_WIDTH);
	wire hit_irq_status = (paddr == PCR_REG_IRQ_STATUS);
	wire hit_irq_mask = (paddr == PCR_REG_IRQ_MASK);
	wire hit_any = hit_req_id | hit_req_index | hit_req_value | hit_decode |
		hit_full_id | hit_result | hit_res_value | hit_rsp_id |
		hit_rsp_value | hit_chan_width | hit_irq_status | hit_irq_mask;

	// Zero-wait slave, error on unmapped address
	assign pready = 1'b1;
	assign pslverr = bus_access & ~hit_any;

	wire [7:0] order_sub = order_index[PCR_SUB_MSB:PCR_SUB_LSB];
	// page selector from top six bits; bits 8 and 9 dropped
	wire [PCR_PAGE_BITS-1:0] order_page = order_index[PCR_PAGE_MSB:PCR_PAGE_LSB];
	wire [10:0] order_pnu = order_id[PCR_PNU_MSB:PCR_PNU_LSB];

	// full identifier from scrambled page plus number
	wire [16:0] page_ofs = pcr_page_offset(order_index);
	wire [PCR_FULL_W-1:0] full_id = 17'(page_ofs + {6'h00, order_pnu});

	// Result command fields from the bus write
	wire res_go = bus_wr & hit_result;
	wire [3:0] res_kind = pwdata[PCR_RES_KIND_MSB:PCR_RES_KIND_LSB];
	wire [3:0] res_err = pwdata[PCR_RES_ERR_MSB:PCR_RES_ERR_LSB];

	// Channel width checks
	wire width_has_word = (chan_width >= PCR_WIDTH_WORD);
	wire width_has_dword = (chan_width >= PCR_WIDTH_DWORD);

	// codes above the error code are reserved
	wire kind_reserved = (res_kind > 4'(PCR_RSP_ERROR));
	// double word kinds need the wide channel
	wire kind_dword = (res_kind == 4'(PCR_RSP_DWORD)) |
		(res_kind == 4'(PCR_RSP_ARR_DWORD));
	wire kind_carries = (res_kind != 4'(PCR_RSP_NONE)) & ~kind_reserved;
	// response would not fit the channel
	wire too_narrow = kind_carries &
		((kind_dword & ~width_has_dword) | ~width_has_word);

	// Final response code selection
	pcr_rsp_t next_code;
	logic [31:0] next_value;
	always_comb begin
		next_code = PCR_RSP_NONE;
		next_value = 32'h00000000;
		// reserved kind becomes an unsupported-order error
		if (kind_reserved) begin
			next_code = PCR_RSP_ERROR;
			next_value = {16'h0000, PCR_ERR_UNSUPPORTED};
		end else if (too_narrow) begin
			next_code = PCR_RSP_ERROR;
			next_value = {16'h0000, PCR_ERR_CHAN_SMALL};
		end else begin
			case (res_kind)
				4'(PCR_RSP_NONE): begin
					next_code = PCR_RSP_NONE;
				end
				// single word value in low half
				4'(PCR_RSP_WORD): begin
					next_code = PCR_RSP_WORD;
					next_value = {16'h0000, res_value[15:0]};
				end
				4'(PCR_RSP_DWORD): begin
					next_code = PCR_RSP_DWORD;
					next_value = res_value;
				end
				4'(PCR_RSP_DESC): begin
					next_code = PCR_RSP_DESC;
					next_value = res_value;
				end
				4'(PCR_RSP_ARR_WORD): begin
					next_code = PCR_RSP_ARR_WORD;
					next_value = {16'h0000, res_value[15:0]};
				end
				4'(PCR_RSP_ARR_DWORD): begin
					next_code = PCR_RSP_ARR_DWORD;
					next_value = res_value;
				end
				4'(PCR_RSP_ARR_COUNT): begin
					next_code = PCR_RSP_ARR_COUNT;
					next_value = res_value;
				end
				4'(PCR_RSP_ERROR): begin
					next_code = PCR_RSP_ERROR;
					next_value = {16'h0000, pcr_err_id(res_err)};
				end
				default: begin
					next_code = PCR_RSP_ERROR;
					next_value = {16'h0000, PCR_ERR_UNSUPPORTED};
				end
			endcase
		end
	end

	// response code in top nibble, number echoed
	wire [15:0] next_id_word = {next_code, 1'b0, order_pnu};
	wire rsp_is_error = (next_code == PCR_RSP_ERROR);

	// Order capture from the link
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			order_id <= 16'h0000;
			order_index <= 16'h0000;
			order_value <= 32'h00000000;
		end else if (req_strobe) begin
			order_id <= req_id_word;
			order_index <= req_index_word;
			order_value <= req_value_field;
		end
	end

	// Software writable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_value <= 32'h00000000;
			chan_width <= PCR_WIDTH_RESET;
			irq_mask <= '0;
		end else begin
			if (bus_wr & hit_res_value) begin
				res_value <= pwdata;
			end
			if (bus_wr & hit_chan_width) begin
				chan_width <= pwdata[2:0];
			end
			if (bus_wr & hit_irq_mask) begin
				irq_mask <= pwdata[PCR_IRQ_W-1:0];
			end
		end
	end

	// Response words, held until the next result command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			parameter_id_word <= 16'h0000;
			rsp_index_word <= 16'h0000;
			parameter_value_field <= 32'h00000000;
			rsp_strobe <= 1'b0;
		end else begin
			rsp_strobe <= res_go;
			if (res_go) begin
				parameter_id_word <= next_id_word;
				rsp_index_word <= order_index;
				parameter_value_field <= next_value;
			end
		end
	end

	// Events; a new event wins over a read clear
	wire [PCR_IRQ_W-1:0] irq_event;
	assign irq_event[PCR_IRQ_ORDER] = req_strobe;
	assign irq_event[PCR_IRQ_SENT] = res_go;
	assign irq_event[PCR_IRQ_ERROR] = res_go & rsp_is_error;
	assign irq_event[PCR_IRQ_RESERVED] = res_go & kind_reserved;
	wire irq_clear = bus_rd & hit_irq_status;
	wire [PCR_IRQ_W-1:0] next_irq_status =
		(irq_clear ? '0 : irq_status) | irq_event;

	// Sticky status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	assign irq = |(irq_status & irq_mask);

	// Read data selection
	always_comb begin
		prdata = 32'h00000000;
		if (bus_rd) begin
			case (1'b1)
				hit_req_id: prdata = {16'h0000, order_id};
				hit_req_index: prdata = {16'h0000, order_index};
				hit_req_value: prdata = order_value;
				hit_decode: prdata = {18'h00000, order_page, order_sub};
				hit_full_id: prdata = {15'h0000, full_id};
				hit_res_value: prdata = res_value;
				hit_rsp_id: prdata = {16'h0000, parameter_id_word};
				hit_rsp_value: prdata = parameter_value_field;
				hit_chan_width: prdata = {29'h00000000, chan_width};
				hit_irq_status: prdata = {28'h0000000, irq_status};
				hit_irq_mask: prdata = {28'h0000000, irq_mask};
				default: prdata = 32'h00000000;
			endcase
		end
	end

endmodule : pcr_responder

// file: sim/pcr_responder_asserts.sv
// Port assertions for the parameter channel responder
`timescale 1ns/1ps
module pcr_responder_asserts
	import pcr_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Access phase
	input wire logic pwrite, // Write
	input wire logic [7:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic rsp_strobe, // Response pulse
	input wire logic [15:0] parameter_id_word, // Response id
	input wire logic [31:0] parameter_value_field // Response value
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Result write and response fields
	wire res_wr = psel && penable && pwrite && paddr == PCR_REG_RESULT;
	wire [3:0] code = parameter_id_word[15:12];
	wire [15:0] eid = parameter_value_field[15:0];
	a_rsp_follows_write: assert property (res_wr |=> rsp_strobe)
		else $error("no response pulse");
	a_rsp_has_cause: assert property (rsp_strobe |-> $past(res_wr))
		else $error("pulse without write");
	a_no_resv_code: assert property (rsp_strobe |-> !code[3])
		else $error("reserved code");
	a_spare_bit_low: assert property (rsp_strobe |-> !parameter_id_word[11])
		else $error("bit 11 set");
	a_none_is_zero: assert property (res_wr && pwdata[3:0] == 4'h0 |=>
		code == 4'h0 && parameter_value_field == 32'h0) else $error("kind 0 wrong");
	a_resv_refused: assert property (res_wr && pwdata[3] |=>
		code == 4'h7 && eid == 16'h006a) else $error("kind 8-15 wrong");
	a_err_word_only: assert property (rsp_strobe && code == 4'h7 |->
		parameter_value_field[31:16] == 16'h0) else $error("error high word");
	a_err_known: assert property (rsp_strobe && code == 4'h7 |->
		eid inside {[16'h0:16'h5], 16'h66, 16'h68, 16'h6a}) else $error("bad error id");
	cp_err: cover property (rsp_strobe && code == 4'h7);
	cp_resv: cover property (res_wr && pwdata[3]);
	cp_dword: cover property (rsp_strobe && code == 4'h2);
endmodule : pcr_responder_asserts

// file: sim/pcr_master_model.sv
// Fieldbus master model that issues parameter orders
`timescale 1ns/1ps
module pcr_master_model (
	input wire logic pclk, // Clock
	output logic req_strobe, // Order pulse
	output logic [15:0] req_id_word, // Identifier word
	output logic [15:0] req_index_word, // Index word
	output logic [31:0] req_value_field // Value field
);
	initial begin
		req_strobe = 1'b0;
		{req_id_word, req_index_word, req_value_field} = '0;
	end
	task automatic send(input logic [15:0] id, input logic [15:0] ix, input logic [31:0] v);
		@(posedge pclk);
		req_strobe <= 1'b1;
		req_id_word <= id;
		req_index_word <= ix;
		req_value_field <= v;
		@(posedge pclk);
		req_strobe <= 1'b0;
		// Stale words shown inverted
		req_id_word <= ~id;
		req_index_word <= ~ix;
		req_value_field <= ~v;
	endtask : send
endmodule : pcr_master_model

// file: sim/parameter_channel_responder_bench.sv
// Self-checking bench for the parameter channel responder
`timescale 1ns/1ps
module parameter_channel_responder_bench;
	import pcr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rsp_strobe, irq, req_strobe, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, req_value_field, parameter_value_field, rd, v;
	logic [15:0] req_id_word, req_index_word, parameter_id_word, rsp_index_word, id, ix;
	int fail_count, n_checks, seed;
	pcr_responder dut (.*);
	pcr_master_model u_mst (.*);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	// One APB transfer, read data in rd
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fail_count++;
			tally_and_finish();
		end
	endtask : apb
	// Wait for response pulse and compare words
	task automatic resp(input logic [3:0] c, input logic [31:0] val);
		int n;
		n = 0;
		#1;
		while (rsp_strobe !== 1'b1 && n < 8) begin
			@(posedge pclk);
			#1;
			n++;
		end
		if (rsp_strobe !== 1'b1) begin
			fail_count++;
			tally_and_finish();
		end
		chk(parameter_id_word[15:12], c);
		chk(parameter_value_field, val);
		chk(parameter_id_word[11:0], {1'b0, id[10:0]});
		chk(rsp_index_word, ix);
		// Pulse lasts one cycle only
		@(posedge pclk);
		#1 chk(rsp_strobe, 0);
		// Same words seen through the register bus
		apb(0, PCR_REG_RSP_ID, 0);
		chk(rd, {16'h0, c, 1'b0, id[10:0]});
		apb(0, PCR_REG_RSP_VALUE, 0);
		chk(rd, val);
	endtask : resp
	function automatic logic [15:0] eid(input logic [3:0] s);
		logic [15:0] t [9] = '{0, 1, 2, 3, 4, 5, 16'h66, 16'h68, 16'h6a};
		return s > 4'h8 ? 16'h6a : t[s];
	endfunction : eid
	function automatic logic [31:0] exp_val(input logic [3:0] k, input logic [31:0] d);
		if (k == 4'h0) return 32'h0;
		if (k == 4'h1 || k == 4'h4) return {16'h0, d[15:0]};
		if (k == 4'h7) return {16'h0, eid(4'h0)};
		return k[3] ? 32'h6a : d;
	endfunction : exp_val
	function automatic logic [16:0] full(input logic [15:0] i, input logic [10:0] p);
		return 17'(p) + (i[15] ? 17'd2000 : 17'd0) + (i[12] ? 17'd4000 : 17'd0)
			+ (i[13] ? 17'd8000 : 17'd0) + (i[14] ? 17'd16000 : 17'd0)
			+ (i[10] ? 17'd32000 : 17'd0) + (i[11] ? 17'd64000 : 17'd0);
	endfunction : full
	initial begin
		seed = 32'haffd;
		fail_count = 0;
		n_checks = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, PCR_REG_CHAN_WIDTH, 0);
		chk(rd, 4);
		chk(err, 0);
		apb(1, PCR_REG_IRQ_MASK, 1);
		// Orders with corner and random index words
		for (int t = 0; t < 12; t++) begin
			id = 16'($random(seed));
			ix = t == 0 ? 16'h0300 : t == 1 ? 16'hfcff : 16'($random(seed));
			v = $random(seed);
			u_mst.send(id, ix, v);
			#1 chk(irq, 1);
			apb(0, PCR_REG_REQ_ID, 0);
			chk(rd, {16'h0, id});
			apb(0, PCR_REG_REQ_INDEX, 0);
			chk(rd, {16'h0, ix});
			apb(0, PCR_REG_REQ_VALUE, 0);
			chk(rd, v);
			apb(0, PCR_REG_DECODE, 0);
			chk(rd, {18'h0, ix[15:10], ix[7:0]});
			apb(0, PCR_REG_FULL_ID, 0);
			chk(rd, {15'h0, full(ix, id[10:0])});
			apb(0, PCR_REG_IRQ_STATUS, 0);
			chk(rd, 32'h1);
			#1 chk(irq, 0);
		end
		$display("decode test done");
		// Every response kind
		for (int k = 0; k < 16; k++) begin
			v = $random(seed);
			apb(1, PCR_REG_RES_VALUE, v);
			apb(0, PCR_REG_RES_VALUE, 0);
			chk(rd, v);
			apb(1, PCR_REG_RESULT, 32'(k));
			resp(k > 7 ? 4'h7 : 4'(k), exp_val(4'(k), v));
		end
		// Sent, error and reserved events are sticky, cleared by the read
		apb(0, PCR_REG_IRQ_STATUS, 0);
		chk(rd, 32'he);
		apb(0, PCR_REG_IRQ_STATUS, 0);
		chk(rd, 32'h0);
		$display("kind test done");
		// Every error selector
		for (int s = 0; s < 10; s++) begin
			apb(1, PCR_REG_RESULT, {20'h0, 4'(s), 8'h07});
			resp(4'h7, {16'h0, eid(4'(s))});
		end
		$display("error test done");
		apb(1, PCR_REG_CHAN_WIDTH, 3);
		apb(1, PCR_REG_RESULT, 2);
		resp(4'h7, 32'h66);
		apb(1, PCR_REG_RESULT, 1);
		resp(4'h1, {16'h0, v[15:0]});
		apb(1, PCR_REG_CHAN_WIDTH, 2);
		apb(1, PCR_REG_RESULT, 1);
		resp(4'h7, 32'h66);
		apb(0, 8'h30, 0);
		chk(err, 1);
		chk(rd, 0);
		apb(1, PCR_REG_IRQ_MASK, 0);
		u_mst.send(id, ix, v);
		#1 chk(irq, 0);
		$display("width test done");
		// Mid-run reset brings outputs and controls back to rest
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({rsp_strobe, irq, parameter_id_word}, 0);
		chk(rsp_index_word, 0);
		chk(parameter_value_field, 0);
		presetn <= 1'b1;
		apb(0, PCR_REG_CHAN_WIDTH, 0);
		chk(rd, 4);
		apb(0, PCR_REG_REQ_ID, 0);
		chk(rd, 0);
		$display("reset test done");
		tally_and_finish();
	end
endmodule : parameter_channel_responder_bench
bind pcr_responder pcr_responder_asserts u_chk (.*);
